// ==== inc/rfcr_regs.vh ====
`ifndef RFCR_REGS_VH
`define RFCR_REGS_VH
// Register indices; byte address is four times the index
`define RFCR_IDX_CRC_HIGH 8'h21
`define RFCR_IDX_CRC_LOW 8'h22
`define RFCR_IDX_RSVD_A 8'h23
`define RFCR_IDX_MOD_WIDTH 8'h24
`define RFCR_IDX_RSVD_B 8'h25
`define RFCR_IDX_RX_GAIN 8'h26
`define RFCR_IDX_NDRV 8'h27
// Extra control register: bit 0 soft power-down, bit 1 driver a on, bit 2 driver b on
`define RFCR_IDX_CTRL 8'h30
`define RFCR_CTRL_PD_BIT 0
`define RFCR_CTRL_DRVA_BIT 1
`define RFCR_CTRL_DRVB_BIT 2
// Reset values
`define RFCR_RST_CRC 8'hff
`define RFCR_RST_RSVD_A 8'h88
`define RFCR_RST_MOD_WIDTH 8'h26
`define RFCR_RST_RSVD_B 8'h87
`define RFCR_RST_RX_GAIN 8'h48
`define RFCR_RST_NDRV 8'h88
`define RFCR_RST_CTRL 8'h00
// Field positions
`define RFCR_GAIN_LSB 4
`define RFCR_GAIN_MSB 6
`define RFCR_CW_MSB 7
`define RFCR_MOD_MSB 3
// Receiver gain in dB per code
`define RFCR_DB_18 6'h12
`define RFCR_DB_23 6'h17
`define RFCR_DB_33 6'h21
`define RFCR_DB_38 6'h26
`define RFCR_DB_43 6'h2b
`define RFCR_DB_48 6'h30
// AXI responses
`define RFCR_RESP_OKAY 2'h0
`define RFCR_RESP_SLVERR 2'h2
`endif

// ==== test/rfcr_props_properties.sv ====
`timescale 1ns/1ps
module rfcr_props (
  input wire clk, // Clock
  input wire rst, // Async reset
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, // Write side
  input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, // Read side
  input wire [31:0] s_axi_rdata, // Read data
  input wire [1:0] s_axi_rresp, // Read response
  input wire mod_pulse, antenna_driver_a, antenna_driver_b, // Pulse, drivers
  input wire [3:0] carrier_ndriver_conductance, modulating_ndriver_conductance, // Fields
  input wire [3:0] active_ndriver_conductance, // Applied now
  input wire [2:0] receiver_gain_select, // Gain code
  input wire [5:0] receiver_gain_db // Gain in dB
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request steps of each side, and both drivers off
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_drv_off; !antenna_driver_a && !antenna_driver_b; endsequence
  // Low codes fold onto 18 and 23 dB
  property p_gain_db; receiver_gain_db == (receiver_gain_select[2] ?
    6'd33 + 6'd5 * receiver_gain_select[1:0] : (receiver_gain_select[0] ? 6'd23 : 6'd18)); endproperty
  a_gain_db: assert property (p_gain_db) else $error("gain dB wrong");
  property p_active; active_ndriver_conductance == ($past(mod_pulse) ?
    modulating_ndriver_conductance : carrier_ndriver_conductance); endproperty
  a_active: assert property (p_active) else $error("applied conductance wrong");
  // Drivers and conductances come from the same control cycle
  property p_nodrv; s_drv_off |-> carrier_ndriver_conductance == 4'h0
    && modulating_ndriver_conductance == 4'h0 && active_ndriver_conductance == 4'h0; endproperty
  a_nodrv: assert property (p_nodrv) else $error("conductance with drivers off");
  property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_wr_ans; s_wr_take |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_width; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
  property p_slverr; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("error read not zero");
endmodule // rfcr_props

bind rfcr_config_regs rfcr_props u_props (.*);

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, crc_result_load, modulate_req, mod_pulse;
  logic antenna_driver_a, antenna_driver_b, ok;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, carrier_ndriver_conductance, modulating_ndriver_conductance, active_ndriver_conductance;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
  logic [15:0] crc_result, crc;
  logic [2:0] receiver_gain_select;
  logic [5:0] receiver_gain_db;
  logic [33:0] rq[$];
  logic [7:0] w, ix[8] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30};
  logic [7:0] rv[8] = '{8'hff, 8'hff, 8'h88, 8'h26, 8'h87, 8'h48, 8'h88, 8'h00};
  integer mismatches = 0, total_checks = 0, i, n;

  rfcr_config_regs dut (.*);

  // 25 MHz clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input [33:0] got, input [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input [7:0] a, input [7:0] d, input [1:0] r);
    ok = 0;
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= {22'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      ok = s_axi_bvalid === 1'b1;
      s_axi_bready <= !ok;
    end
    chk(ok, 1);
    if (!ok) report_and_stop();
  endtask

  // Ready raised only once data shows, so the slave must hold it
  task automatic rd(input [7:0] a, input [7:0] d, input [1:0] r);
    ok = 0;
    rq.push_back({r, 24'h0, d});
    @(posedge clk);
    s_axi_araddr <= {22'h0, a, 2'h0};
    s_axi_arvalid <= 1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      ok = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
      s_axi_rready <= s_axi_rvalid === 1'b1 && !ok;
    end
    chk(ok, 1);
    if (!ok) report_and_stop();
  endtask

  // Answers judged in order of issue
  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk(s_axi_bresp, bq.pop_front());
  end

  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, crc_result_load} = 7'h40;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, crc_result, modulate_req} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(81));
    repeat (10) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 8; i++) rd(ix[i], rv[i], 2'h0);
    // Read-only and reserved places ignore writes
    for (i = 0; i < 5; i++) begin
      if (i != 3) wr(ix[i], 8'($urandom), 2'h0);
      rd(ix[i], rv[i], 2'h0);
    end
    wr(8'h20, 8'h5a, 2'h2);
    rd(8'h20, 8'h00, 2'h2);
    // Lane 0 strobe low: the write completes but changes nothing
    s_axi_wstrb <= 4'he;
    wr(8'h24, 8'h5a, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h24, 8'h26, 2'h0);
    // Every gain code, reserved bits keep reset value
    for (i = 0; i < 8; i++) begin
      wr(8'h26, {1'b1, 3'(i), 4'h3}, 2'h0);
      rd(8'h26, {1'b0, 3'(i), 4'h8}, 2'h0);
      chk(receiver_gain_db, i[2] ? 33 + 5 * i[1:0] : (i[0] ? 23 : 18));
      chk(receiver_gain_select, i[2:0]);
    end
    // Conductance fields, power-down forcing, driver gating
    wr(8'h30, 8'h06, 2'h0);
    wr(8'h27, 8'h35, 2'h0);
    rd(8'h30, 8'h06, 2'h0);
    chk({carrier_ndriver_conductance, modulating_ndriver_conductance}, 8'h35);
    chk({antenna_driver_a, antenna_driver_b}, 2'h3);
    rd(8'h27, 8'h35, 2'h0);
    wr(8'h30, 8'h07, 2'h0);
    rd(8'h30, 8'h07, 2'h0);
    chk({carrier_ndriver_conductance, modulating_ndriver_conductance}, 8'hbd);
    wr(8'h30, 8'h01, 2'h0);
    rd(8'h30, 8'h01, 2'h0);
    chk({carrier_ndriver_conductance, modulating_ndriver_conductance}, 8'h00);
    chk({antenna_driver_a, antenna_driver_b}, 2'h0);
    wr(8'h30, 8'h06, 2'h0);
    // Zero width and a random width kept under half a bit
    for (i = 0; i < 2; i++) begin
      w = i ? 8'($urandom % 40) : 8'h00;
      wr(8'h24, w, 2'h0);
      rd(8'h24, w, 2'h0);
      @(posedge clk);
      modulate_req <= 1;
      @(posedge clk);
      modulate_req <= 0;
      n = 0;
      repeat (60) begin
        @(posedge clk);
        n += (mod_pulse === 1'b1);
      end
      chk(n, w + 1);
    end
    // Captured value must survive the source changing
    crc = 16'($urandom);
    @(posedge clk);
    crc_result <= crc;
    crc_result_load <= 1;
    @(posedge clk);
    crc_result_load <= 0;
    crc_result <= ~crc;
    rd(8'h21, crc[15:8], 2'h0);
    rd(8'h22, crc[7:0], 2'h0);
    report_and_stop();
  end
endmodule // tb

// ==== verilog/rfcr_config_regs.v ====
// Notes on behaviour
// - CRC high byte read-only, resets to ff, shows latest CRC result.
// - CRC low byte read-only, resets to ff, shows latest CRC result.
// - Reserved location after CRC bytes, no function, resets to 88.
// - Reserved location before gain register, no function, resets to 87.
// - Modulation pulse width register fully read/write, resets to 26.
// - Each Miller pulse lasts programmed width plus one carrier periods.
// - Gain register resets to 48, gain field bits 6:4, rest reserved.
// - Gain codes map to 18,23,18,23,33,38,43,48 dB.
// - Conductance register resets to 88, carrier field 7:4, modulation 3:0.
// - Carrier conductance drives both antenna drivers when not modulating.
// - Modulation conductance sets the modulation index.
// - Soft power-down forces top bit of each conductance field to one.
// - Conductance used only while an antenna driver is switched on.
`timescale 1ns/1ps
`include "rfcr_regs.vh"

module rfcr_config_regs (
  input wire clk, // 25 MHz clock
  input wire rst, // Async reset, active high
  input wire [31:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [31:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [15:0] crc_result, // CRC engine result
  input wire crc_result_load, // Pulse: new CRC result
  input wire modulate_req, // Pulse: start one Miller pulse
  output reg mod_pulse, // Miller modulation pulse
  output reg antenna_driver_a, // Driver a enable
  output reg antenna_driver_b, // Driver b enable
  output reg [3:0] carrier_ndriver_conductance, // Effective carrier n-conductance
  output reg [3:0] modulating_ndriver_conductance, // Effective modulation n-conductance
  output reg [3:0] active_ndriver_conductance, // Conductance applied now
  output reg [2:0] receiver_gain_select, // Gain code to receiver
  output reg [5:0] receiver_gain_db // Selected gain in dB
);

  reg [7:0] crc_result_high_byte;
  reg [7:0] crc_result_low_byte;
  reg [7:0] pulse_width_value;
  reg [2:0] gain_field;
  reg [7:0] ndriver_conductance;
  reg [2:0] ctrl;
  reg [7:0] width_cnt;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_idx;
  reg [7:0] wdata_b;
  reg wstrb0;
  reg [7:0] next_rdata;
  reg next_rerr;
  reg [3:0] next_cw;
  reg [3:0] next_mod;
  reg [5:0] next_db;
  wire wr_fire;
  wire [7:0] ar_idx;
  wire soft_pd;
  wire drv_on;
  reg wr_known;
  wire wr_lane0;
  wire wr_mod;
  wire wr_gain;
  wire wr_ndrv;
  wire wr_ctrl;

  assign ar_idx = s_axi_araddr[9:2];
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign soft_pd = ctrl[`RFCR_CTRL_PD_BIT];
  assign drv_on = ctrl[`RFCR_CTRL_DRVA_BIT] | ctrl[`RFCR_CTRL_DRVB_BIT];

  // Per-register write enables; only byte lane 0 carries a register
  assign wr_lane0 = wr_fire && wstrb0;
  assign wr_mod = wr_lane0 && (aw_idx == `RFCR_IDX_MOD_WIDTH);
  assign wr_gain = wr_lane0 && (aw_idx == `RFCR_IDX_RX_GAIN);
  assign wr_ndrv = wr_lane0 && (aw_idx == `RFCR_IDX_NDRV);
  assign wr_ctrl = wr_lane0 && (aw_idx == `RFCR_IDX_CTRL);

  // Write address: ready pulses once, index held until the response is raised
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  // Write data: taken on its own, so address and data may come in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      wdata_b <= 8'h00;
      wstrb0 <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_b <= s_axi_wdata[7:0];
        wstrb0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Index check for writes; a miss still completes, with an error response
  always @* begin
    wr_known = 1'b0;
    if (aw_idx == `RFCR_IDX_CRC_HIGH) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_CRC_LOW) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_RSVD_A) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_MOD_WIDTH) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_RSVD_B) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_RX_GAIN) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_NDRV) begin
      wr_known = 1'b1;
    end else if (aw_idx == `RFCR_IDX_CTRL) begin
      wr_known = 1'b1;
    end
  end

  // Write response; held until the master takes it, no new write before then
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RFCR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `RFCR_RESP_OKAY : `RFCR_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Modulation pulse width, all eight bits writable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_width_value <= `RFCR_RST_MOD_WIDTH;
    end else if (wr_mod) begin
      pulse_width_value <= wdata_b;
    end
  end

  // Gain field only; reserved bits of that word are never stored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_field <= 3'h4;
    end else if (wr_gain) begin
      gain_field <= wdata_b[`RFCR_GAIN_MSB:`RFCR_GAIN_LSB];
    end
  end

  // Both conductance fields live in one byte
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ndriver_conductance <= `RFCR_RST_NDRV;
    end else if (wr_ndrv) begin
      ndriver_conductance <= wdata_b;
    end
  end

  // Power-down and driver enables; stands in for controls kept elsewhere
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= 3'h0;
    end else if (wr_ctrl) begin
      ctrl <= wdata_b[2:0];
    end
  end

  // CRC high byte; trusted only once the engine flags it done
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_result_high_byte <= `RFCR_RST_CRC;
    end else if (crc_result_load) begin
      crc_result_high_byte <= crc_result[15:8];
    end
  end

  // CRC low byte, loaded on the same strobe so both halves match
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_result_low_byte <= `RFCR_RST_CRC;
    end else if (crc_result_load) begin
      crc_result_low_byte <= crc_result[7:0];
    end
  end

  // Read mux
  always @* begin
    next_rerr = 1'b0;
    if (ar_idx == `RFCR_IDX_CRC_HIGH) begin
      next_rdata = crc_result_high_byte;
    end else if (ar_idx == `RFCR_IDX_CRC_LOW) begin
      next_rdata = crc_result_low_byte;
    end else if (ar_idx == `RFCR_IDX_RSVD_A) begin
      next_rdata = `RFCR_RST_RSVD_A;
    end else if (ar_idx == `RFCR_IDX_MOD_WIDTH) begin
      next_rdata = pulse_width_value;
    end else if (ar_idx == `RFCR_IDX_RSVD_B) begin
      next_rdata = `RFCR_RST_RSVD_B;
    end else if (ar_idx == `RFCR_IDX_RX_GAIN) begin
      next_rdata = {1'b0, gain_field, 4'h8};
    end else if (ar_idx == `RFCR_IDX_NDRV) begin
      next_rdata = ndriver_conductance;
    end else if (ar_idx == `RFCR_IDX_CTRL) begin
      next_rdata = {5'h00, ctrl};
    end else begin
      next_rdata = 8'h00;
      next_rerr = 1'b1;
    end
  end

  // Read channel: address taken, data one cycle later
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RFCR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, next_rdata};
        s_axi_rresp <= next_rerr ? `RFCR_RESP_SLVERR : `RFCR_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Miller pulse: width+1 clocks; clk stands in for the carrier clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_pulse <= 1'b0;
      width_cnt <= 8'h00;
    end else if (mod_pulse) begin
      if (width_cnt == 8'h00) begin
        mod_pulse <= 1'b0;
      end else begin
        width_cnt <= width_cnt - 8'h01;
      end
    end else if (modulate_req) begin
      mod_pulse <= 1'b1;
      width_cnt <= pulse_width_value;
    end
  end

  // Effective conductances: power-down forcing first, then driver gating
  always @* begin
    next_cw = ndriver_conductance[7:4];
    next_mod = ndriver_conductance[3:0];
    if (soft_pd) begin
      next_cw[3] = 1'b1;
      next_mod[3] = 1'b1;
    end
    if (!drv_on) begin
      next_cw = 4'h0;
      next_mod = 4'h0;
    end
  end

  // Gain decode; the low codes fold onto two values
  always @* begin
    case (gain_field)
      3'h0, 3'h2: next_db = `RFCR_DB_18;
      3'h1, 3'h3: next_db = `RFCR_DB_23;
      3'h4: next_db = `RFCR_DB_33;
      3'h5: next_db = `RFCR_DB_38;
      3'h6: next_db = `RFCR_DB_43;
      default: next_db = `RFCR_DB_48;
    endcase
  end

  // Conductance outputs; the applied value follows the pulse one clock late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_ndriver_conductance <= 4'h0;
      modulating_ndriver_conductance <= 4'h0;
      active_ndriver_conductance <= 4'h0;
    end else begin
      carrier_ndriver_conductance <= next_cw;
      modulating_ndriver_conductance <= next_mod;
      active_ndriver_conductance <= mod_pulse ? next_mod : next_cw;
    end
  end

  // Driver enables, registered so they line up with the conductances
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      antenna_driver_a <= 1'b0;
      antenna_driver_b <= 1'b0;
    end else begin
      antenna_driver_a <= ctrl[`RFCR_CTRL_DRVA_BIT];
      antenna_driver_b <= ctrl[`RFCR_CTRL_DRVB_BIT];
    end
  end

  // Gain outputs to the receiver
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receiver_gain_select <= 3'h4;
      receiver_gain_db <= `RFCR_DB_33;
    end else begin
      receiver_gain_select <= gain_field;
      receiver_gain_db <= next_db;
    end
  end

endmodule // rfcr_config_regs
